// file: comb_ctrl_pkg.sv
// Shared constants and types of the comb filter control and separation block.
// Assumes a single pixel clock domain plus a serial clock driven by the host.
package comb_ctrl_pkg;

  // Serial command framing.
  localparam logic [7:0] DEV_ADDR = 8'hb3;
  localparam logic [4:0] FRAME_EDGES = 5'h14;
  localparam logic [4:0] EDGE_SAT = 5'h1f;
  localparam int SHIFT_W = 19;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 11;
  localparam int DATA_HI = 9;
  localparam int DATA_LO = 2;

  // Control field codes.
  localparam logic [2:0] THR_AUTO = 3'h0;
  localparam logic [1:0] MODE_ADAPT_A = 2'h0;
  localparam logic [1:0] MODE_ADAPT_B = 2'h1;
  localparam logic [1:0] MODE_COMB = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // Arithmetic.
  localparam int FRAC = 4;
  localparam int TRACK_SHIFT = 6;
  localparam int ACC_W = 18;
  localparam logic [4:0] FADE_MAX = 5'h10;
  localparam logic [7:0] CHROMA_MID = 8'h80;
  localparam int LINE_LEN_DEF = 858;

  typedef struct packed {
    logic bypass;
    logic [2:0] thr;
    logic [1:0] mode;
    logic square;
    logic pal;
  } ctrl_t;

  typedef struct packed {
    logic sp;
    logic sda;
    logic scl;
  } pins_t;

  // Pin synchroniser value after reset. The serial lines idle high. Select is taken as
  // high so that a select held high through reset is not mistaken for a fresh strobe.
  localparam pins_t PINS_RESET = 3'h7;

  typedef struct packed {
    logic [7:0] chroma;
    logic [11:0] comp;
  } pix_t;

  typedef logic signed [15:0] sample_t;

  typedef enum logic [0:0] {SER_IDLE, SER_FRAME} ser_state_t;
  typedef enum logic [1:0] {PATH_ADAPT, PATH_COMB, PATH_SPLIT} path_t;

endpackage : comb_ctrl_pkg

// file: comb_filter_control.sv
// Control register loading (serial and parallel) and line comb separation.
// Assumes video pins are synchronous to clock_i; the serial pins are not.
//
// What this block does
// [RULE1] Serial select low: control bytes shift in on serial data, clocked by serial clock.
// [RULE2] A serial transfer is an 8-bit address then 8 data bits for control.
// [RULE3] The device address recognised on the serial bus is b3 hex.
// [RULE4] Start cycle 0, address 1-8, decode 9, data 10-17, strobe 18, stop 19.
// [RULE5] Stop is serial data rising while serial clock stays high.
// [RULE6] In parallel mode program pin n supplies control bit n.
// [RULE7] A rising select pin loads the eight program pins into the control register.
// [RULE8] Select low re-enables serial loading; select high makes the serial port ignore traffic.
// [RULE9] Threshold field 000 selects automatic threshold tracking.
// [RULE10] Threshold codes 001 to 111 give graded fixed thresholds.
// [RULE11] Mode 00: NTSC Y adaptive C combed, PAL both adaptive; 01 swaps.
// [RULE12] Mode 10 forces full combing of luma and chroma.
// [RULE13] Mode 11 uses bandsplit filtering only.
// [RULE14] NTSC comb luma weights lines 0.25, 0.50, 0.25 and sums.
// [RULE15] Chroma is the original signal minus the comb luma.
// [RULE16] PAL combines first and third lines, scaled, then subtracts for chroma.
// [RULE17] Where combing fails, use bandsplit output with luma peaking.
// [RULE18] Comb and bandsplit blend through a continuous stepwise fader.
// [RULE19] Automatic threshold settles over about sixty lines of weighting.
// [RULE20] Separation arithmetic runs at 12-bit precision.
// [RULE21] Control bit 7 high passes separate luma and chroma uncombed.
// [RULE22] Bit 1 selects square pixel rate, bit 0 selects PAL.
// [RULE23] Reset clears the control register to zero.
// [RULE24] A serial transfer with a wrong address leaves control unchanged.
module comb_filter_control #(
  parameter int LINE_LEN = comb_ctrl_pkg::LINE_LEN_DEF
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic program_select_i,
  input wire logic [7:0] composite_video_input_i,
  input wire logic [7:0] chroma_in_or_program_bits_i,
  output logic [7:0] luma_o,
  output logic [7:0] chroma_o,
  output logic [7:0] comb_control_o
);

  localparam int PIX_W = $clog2(LINE_LEN);
  localparam logic [PIX_W-1:0] LINE_LAST = PIX_W'(LINE_LEN - 1);

  if (LINE_LEN < 4) begin : g_bad_len
    $error("LINE_LEN must be at least 4");
  end

  typedef struct packed {
    comb_ctrl_pkg::pins_t s1;
    comb_ctrl_pkg::pins_t s2;
    comb_ctrl_pkg::pins_t s3;
    comb_ctrl_pkg::pins_t lvl;
    comb_ctrl_pkg::pins_t prev;
    logic [comb_ctrl_pkg::SHIFT_W-1:0] w1;
    logic [comb_ctrl_pkg::SHIFT_W-1:0] w2;
    comb_ctrl_pkg::ser_state_t ser;
    logic [4:0] edges;
    comb_ctrl_pkg::ctrl_t ctrl;
    comb_ctrl_pkg::pix_t inp;
    logic [PIX_W-1:0] pix;
    comb_ctrl_pkg::pix_t b0;
    comb_ctrl_pkg::pix_t b1;
    comb_ctrl_pkg::pix_t b2;
    comb_ctrl_pkg::pix_t a0;
    comb_ctrl_pkg::pix_t a1;
    comb_ctrl_pkg::pix_t c0;
    comb_ctrl_pkg::pix_t c1;
    logic [4:0] yk;
    logic [4:0] ck;
    logic [11:0] peak;
    logic [comb_ctrl_pkg::ACC_W-1:0] acc;
    logic [7:0] luma;
    logic [7:0] chroma;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    s.s1 = comb_ctrl_pkg::PINS_RESET;
    s.s2 = comb_ctrl_pkg::PINS_RESET;
    s.s3 = comb_ctrl_pkg::PINS_RESET;
    s.lvl = comb_ctrl_pkg::PINS_RESET;
    s.prev = comb_ctrl_pkg::PINS_RESET;
    return s;
  endfunction : reset_state

  localparam state_t ST_RESET = reset_state();

  // The serial clock domain only shifts; the word is read by the pixel domain
  // after a stop, when the serial clock stands high and the word is static.
  logic [comb_ctrl_pkg::SHIFT_W-1:0] shift_ff;

  always_ff @(posedge serial_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      shift_ff <= '0;
    else
      shift_ff <= {shift_ff[comb_ctrl_pkg::SHIFT_W-2:0], serial_data_i}; // see [RULE1]
  end

  // Two line stores; reads are combinational so the old word is seen before
  // the write at the same position.
  comb_ctrl_pkg::pix_t line1 [LINE_LEN];
  comb_ctrl_pkg::pix_t line2 [LINE_LEN];
  comb_ctrl_pkg::pix_t rd1;
  comb_ctrl_pkg::pix_t rd2;

  assign rd1 = line1[st_ff.pix];
  assign rd2 = line2[st_ff.pix];

  always_ff @(posedge clock_i)
  begin
    line1[st_ff.pix] <= st_ff.inp;
    line2[st_ff.pix] <= rd1;
  end

  // A pin level changes only once the second and third stages agree.
  comb_ctrl_pkg::pins_t lvl_nxt;
  for (genvar i = 0; i < $bits(comb_ctrl_pkg::pins_t); i++) begin : g_pin
    assign lvl_nxt[i] = (st_ff.s2[i] == st_ff.s3[i]) ? st_ff.s2[i] : st_ff.lvl[i];
  end

  logic scl_rise;
  logic start_ev;
  logic stop_ev;
  logic par_rise;
  logic addr_ok;
  logic ser_load;
  logic line_end;

  assign scl_rise = st_ff.lvl.scl & ~st_ff.prev.scl;
  assign start_ev = st_ff.lvl.scl & st_ff.prev.scl & st_ff.prev.sda & ~st_ff.lvl.sda;
  assign stop_ev = st_ff.lvl.scl & st_ff.prev.scl & ~st_ff.prev.sda & st_ff.lvl.sda; // see [RULE5]
  assign par_rise = st_ff.lvl.sp & ~st_ff.prev.sp;
  assign addr_ok = st_ff.w2[comb_ctrl_pkg::ADDR_HI:comb_ctrl_pkg::ADDR_LO]
                   == comb_ctrl_pkg::DEV_ADDR; // see [RULE3] see [RULE24]
  assign ser_load = stop_ev && st_ff.ser == comb_ctrl_pkg::SER_FRAME && !st_ff.lvl.sp
                    && st_ff.edges == comb_ctrl_pkg::FRAME_EDGES && addr_ok; // see [RULE4]
  assign line_end = st_ff.pix == LINE_LAST;

  function automatic comb_ctrl_pkg::sample_t widen(input logic [11:0] v);
    return comb_ctrl_pkg::sample_t'({4'h0, v});
  endfunction : widen

  function automatic logic [7:0] sat8(input comb_ctrl_pkg::sample_t v);
    if (v < 0)
      return 8'h00;
    else if (v > $signed(16'h00ff))
      return 8'hff;
    else
      return v[7:0];
  endfunction : sat8

  function automatic comb_ctrl_pkg::sample_t fade(input logic [4:0] k,
                                                  input comb_ctrl_pkg::sample_t comb,
                                                  input comb_ctrl_pkg::sample_t bs);
    logic signed [21:0] t;
    t = $signed({1'b0, k}) * comb + $signed({1'b0, comb_ctrl_pkg::FADE_MAX - k}) * bs;
    return t[19:4];
  endfunction : fade

  function automatic logic [4:0] step(input logic [4:0] k, input logic [4:0] tgt);
    if (k < tgt)
      return k + 5'h01;
    else if (k > tgt)
      return k - 5'h01;
    else
      return k;
  endfunction : step

  function automatic logic [4:0] target(input comb_ctrl_pkg::path_t p, input logic comb_ok);
    case (p)
      comb_ctrl_pkg::PATH_COMB: return comb_ctrl_pkg::FADE_MAX;
      comb_ctrl_pkg::PATH_SPLIT: return 5'h00;
      default: return comb_ok ? comb_ctrl_pkg::FADE_MAX : 5'h00;
    endcase
  endfunction : target

  // Samples carry four fraction bits below the 8-bit video: 12-bit working precision.
  comb_ctrl_pkg::sample_t sa;
  comb_ctrl_pkg::sample_t sb;
  comb_ctrl_pkg::sample_t sc;
  comb_ctrl_pkg::sample_t sb0;
  comb_ctrl_pkg::sample_t sb2;
  comb_ctrl_pkg::sample_t y_comb;
  comb_ctrl_pkg::sample_t c_comb;
  comb_ctrl_pkg::sample_t low;
  comb_ctrl_pkg::sample_t high;
  comb_ctrl_pkg::sample_t y_bs;
  comb_ctrl_pkg::sample_t c_bs;
  comb_ctrl_pkg::sample_t diff;
  comb_ctrl_pkg::sample_t absd;
  comb_ctrl_pkg::sample_t yf;
  comb_ctrl_pkg::sample_t cf;
  logic [11:0] art;
  logic [11:0] thr_sel;
  logic comb_ok;
  logic c_forced;
  comb_ctrl_pkg::path_t y_path;
  comb_ctrl_pkg::path_t c_path;

  assign sa = widen(st_ff.a1.comp); // see [RULE20]
  assign sb = widen(st_ff.b1.comp);
  assign sc = widen(st_ff.c1.comp);
  assign sb0 = widen(st_ff.b0.comp);
  assign sb2 = widen(st_ff.b2.comp);
  // PAL lines one and three are 180 degrees apart, so their mean holds no chroma.
  assign y_comb = st_ff.ctrl.pal ? (sa + sc) >>> 1 : (sa + (sb <<< 1) + sc) >>> 2; // see [RULE14] see [RULE16]
  assign c_comb = sb - y_comb; // see [RULE15]
  assign low = (sb0 + (sb <<< 1) + sb2) >>> 2;
  assign high = sb - low;
  // Peaking adds back part of the high band so notched luma keeps its edges.
  assign y_bs = low + (high >>> 3); // see [RULE17]
  assign c_bs = high;
  assign diff = sa - sc;
  assign absd = diff[15] ? -diff : diff;
  assign art = absd[11:0];
  assign thr_sel = (st_ff.ctrl.thr == comb_ctrl_pkg::THR_AUTO)
                   ? st_ff.acc[comb_ctrl_pkg::ACC_W-1 -: 12] // see [RULE9]
                   : {st_ff.ctrl.thr, 9'h000}; // see [RULE10]
  assign comb_ok = art < thr_sel;
  assign c_forced = (st_ff.ctrl.mode == comb_ctrl_pkg::MODE_ADAPT_A && !st_ff.ctrl.pal)
                    || (st_ff.ctrl.mode == comb_ctrl_pkg::MODE_ADAPT_B && st_ff.ctrl.pal); // see [RULE11]
  assign yf = fade(st_ff.yk, y_comb, y_bs); // see [RULE18]
  assign cf = fade(st_ff.ck, c_comb, c_bs);

  always_comb
  begin
    case (st_ff.ctrl.mode)
      comb_ctrl_pkg::MODE_COMB:
      begin
        y_path = comb_ctrl_pkg::PATH_COMB; // see [RULE12]
        c_path = comb_ctrl_pkg::PATH_COMB;
      end
      comb_ctrl_pkg::MODE_SPLIT:
      begin
        y_path = comb_ctrl_pkg::PATH_SPLIT; // see [RULE13]
        c_path = comb_ctrl_pkg::PATH_SPLIT;
      end
      default:
      begin
        y_path = comb_ctrl_pkg::PATH_ADAPT;
        c_path = c_forced ? comb_ctrl_pkg::PATH_COMB : comb_ctrl_pkg::PATH_ADAPT;
      end
    endcase
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = '{sp: program_select_i, sda: serial_data_i, scl: serial_clk_i};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.lvl = lvl_nxt;
    nxt_st.prev = st_ff.lvl;
    nxt_st.w1 = shift_ff;
    nxt_st.w2 = st_ff.w1;

    case (st_ff.ser)
      comb_ctrl_pkg::SER_IDLE:
      begin
        if (start_ev && !st_ff.lvl.sp)
        begin
          nxt_st.ser = comb_ctrl_pkg::SER_FRAME;
          nxt_st.edges = 5'h00;
        end
      end
      comb_ctrl_pkg::SER_FRAME:
      begin
        if (st_ff.lvl.sp)
          nxt_st.ser = comb_ctrl_pkg::SER_IDLE; // see [RULE8]
        else if (start_ev)
          nxt_st.edges = 5'h00;
        else if (stop_ev)
          nxt_st.ser = comb_ctrl_pkg::SER_IDLE;
        else if (scl_rise && st_ff.edges != comb_ctrl_pkg::EDGE_SAT)
          nxt_st.edges = st_ff.edges + 5'h01; // see [RULE4]
      end
      default: nxt_st.ser = comb_ctrl_pkg::SER_IDLE;
    endcase

    if (par_rise)
      nxt_st.ctrl = comb_ctrl_pkg::ctrl_t'(st_ff.inp.chroma); // see [RULE6] see [RULE7]
    else if (ser_load)
      nxt_st.ctrl = comb_ctrl_pkg::ctrl_t'(st_ff.w2[comb_ctrl_pkg::DATA_HI:comb_ctrl_pkg::DATA_LO]); // see [RULE2]

    nxt_st.inp = '{chroma: chroma_in_or_program_bits_i, comp: {composite_video_input_i, 4'h0}};
    nxt_st.pix = line_end ? '0 : st_ff.pix + PIX_W'(1);
    nxt_st.b0 = rd1;
    nxt_st.b1 = st_ff.b0;
    nxt_st.b2 = st_ff.b1;
    nxt_st.a0 = rd2;
    nxt_st.a1 = st_ff.a0;
    nxt_st.c0 = st_ff.inp;
    nxt_st.c1 = st_ff.c0;
    nxt_st.yk = step(st_ff.yk, target(y_path, comb_ok));
    nxt_st.ck = step(st_ff.ck, target(c_path, comb_ok));

    // First-order tracking with weight 1/64 per line: settles in roughly sixty lines.
    if (line_end)
    begin
      nxt_st.acc = st_ff.acc - (st_ff.acc >> comb_ctrl_pkg::TRACK_SHIFT)
                   + {7'h00, st_ff.peak[11:1]}; // see [RULE19]
      nxt_st.peak = 12'h000;
    end
    else if (art > st_ff.peak)
      nxt_st.peak = art;

    if (st_ff.ctrl.bypass)
    begin
      nxt_st.luma = st_ff.b1.comp[11:4]; // see [RULE21]
      nxt_st.chroma = st_ff.b1.chroma;
    end
    else
    begin
      nxt_st.luma = sat8(yf >>> comb_ctrl_pkg::FRAC);
      nxt_st.chroma = sat8((cf >>> comb_ctrl_pkg::FRAC) + $signed({8'h00, comb_ctrl_pkg::CHROMA_MID}));
    end
  end

  // The control register and the datapath registers clear to zero, but the two line stores are not reset; the pin stages take idle levels.
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_ff <= ST_RESET; // see [RULE23]
    else
      st_ff <= nxt_st;
  end

  assign luma_o = st_ff.luma;
  assign chroma_o = st_ff.chroma;
  assign comb_control_o = st_ff.ctrl; // see [RULE22]

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  ser_load_a: assert property (ser_load && !par_rise |=> st_ff.ctrl == $past(st_ff.w2[9:2])) // see [RULE2]
    else $error("serial data byte not loaded");
  addr_miss_a: assert property (stop_ev && !addr_ok && !par_rise |=> $stable(st_ff.ctrl)) // see [RULE24]
    else $error("control changed on foreign address");
  par_load_a: assert property (par_rise |=> st_ff.ctrl == $past(st_ff.inp.chroma)) // see [RULE7]
    else $error("parallel strobe did not load pins");
  sp_ignore_a: assert property (st_ff.lvl.sp |=> st_ff.ser == comb_ctrl_pkg::SER_IDLE) // see [RULE8]
    else $error("serial frame active while select high");
  edge_count_a: assert property (st_ff.ser == comb_ctrl_pkg::SER_FRAME && scl_rise
      && !st_ff.lvl.sp && st_ff.edges < 5'h1f |=> st_ff.edges == $past(st_ff.edges) + 5'h01) // see [RULE4]
    else $error("serial clock edge not counted");
  fade_slew_a: assert property (##1 (st_ff.yk == $past(st_ff.yk) // see [RULE18]
      || st_ff.yk == $past(st_ff.yk) + 5'h01 || st_ff.yk == $past(st_ff.yk) - 5'h01))
    else $error("fader jumped more than one step");
  split_fade_a: assert property (st_ff.ctrl.mode == comb_ctrl_pkg::MODE_SPLIT
      && st_ff.ck != 5'h00 |=> st_ff.ck == $past(st_ff.ck) - 5'h01) // see [RULE13]
    else $error("bandsplit mode not fading out");
  comb_fade_a: assert property (st_ff.ctrl.mode == comb_ctrl_pkg::MODE_COMB
      && st_ff.yk != 5'h10 |=> st_ff.yk == $past(st_ff.yk) + 5'h01) // see [RULE12]
    else $error("forced comb mode not fading in");
  bypass_a: assert property (st_ff.ctrl.bypass |=> luma_o == $past(st_ff.b1.comp[11:4])
      && chroma_o == $past(st_ff.b1.chroma)) // see [RULE21]
    else $error("bypass output mismatch");

endmodule : comb_filter_control

// file: comb_host_model.sv
// Host model: drives the two serial control lines of the comb filter block.
// Assumes the bench owns the select and program pins; both lines idle high as with pull-ups.
module comb_host_model (
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam realtime HALF = 32ns;

  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // The serial clock only runs inside a frame, so it stands high between frames.
  // A pulse count other than 20 lets a scenario send a malformed frame on purpose.
  task automatic send_frame(input logic [7:0] addr, input logic [7:0] data, input int pulses);
    logic [19:0] bits;
    bits = {1'b0, addr, 1'b0, data, 2'b00};
    #5.7ns;
    sda_o = 1'b0;
    #(HALF);
    for (int k = 0; k < pulses; k++)
    begin
      scl_o = 1'b0;
      #(HALF / 2) sda_o = bits[19 - (k % 20)];
      #(HALF / 2) scl_o = 1'b1;
      #(HALF);
    end
    sda_o = 1'b1;
    #(HALF * 4);
  endtask : send_frame
endmodule : comb_host_model

// file: test_comb_filter_control_and_separation.sv
// Self-checking bench of the comb filter control and separation block.
// Assumes the host model drives the serial lines; the bench drives select and video pins.
`define CHECK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_comb_filter_control_and_separation;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LINE = 8;
  localparam int LAT = LINE + 4;

  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic scl;
  logic sda;
  logic sel = 1'b0;
  logic [7:0] comp = 8'h00;
  logic [7:0] pins = 8'h00;
  logic [7:0] luma;
  logic [7:0] chroma;
  logic [7:0] ctrl;
  int mismatches = 0;
  int comparisons = 0;

  always #2 clock = ~clock;

  comb_host_model host_u (
    .scl_o(scl),
    .sda_o(sda)
  );

  comb_filter_control #(.LINE_LEN(LINE)) dut_u (
    .clock_i(clock),
    .arst_n_i(arst_n),
    .serial_clk_i(scl),
    .serial_data_i(sda),
    .program_select_i(sel),
    .composite_video_input_i(comp),
    .chroma_in_or_program_bits_i(pins),
    .luma_o(luma),
    .chroma_o(chroma),
    .comb_control_o(ctrl)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic ser(input logic [7:0] addr, input logic [7:0] data, input int pulses);
    host_u.send_frame(addr, data, pulses);
    tick(12);
  endtask : ser

  // Select is dropped long enough for the synchroniser to see a clean rising edge.
  task automatic load_par(input logic [7:0] v);
    pins = v;
    sel = 1'b0;
    tick(8);
    sel = 1'b1;
    tick(12);
  endtask : load_par

  task automatic test_reset;
    `CHECK(ctrl, 8'h00)
    `CHECK(luma, 8'h00)
  endtask : test_reset

  // A reset in mid-run with select held high must not look like a parallel strobe.
  task automatic test_reset_held_select;
    arst_n = 1'b0;
    tick(2);
    `CHECK(ctrl, 8'h00)
    `CHECK(luma, 8'h00)
    arst_n = 1'b1;
    tick(12);
    `CHECK(ctrl, 8'h00)
    sel = 1'b0;
    tick(8);
    ser(8'hb3, 8'h96, 20);
    `CHECK(ctrl, 8'h96)
  endtask : test_reset_held_select

  task automatic test_serial;
    ser(8'hb3, 8'h5a, 20);
    `CHECK(ctrl, 8'h5a)
    ser(8'hb2, 8'ha5, 20);
    `CHECK(ctrl, 8'h5a)
    ser(8'hb3, 8'ha5, 19);
    `CHECK(ctrl, 8'h5a)
    ser(8'hb3, 8'ha5, 21);
    `CHECK(ctrl, 8'h5a)
  endtask : test_serial

  task automatic test_codes;
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {1'b0, i[2:0], i[1:0], i[0], ~i[0]};
      ser(8'hb3, v, 20);
      `CHECK(ctrl[6:4], i[2:0])
      `CHECK(ctrl[3:2], i[1:0])
      `CHECK(ctrl[1:0], {i[0], ~i[0]})
    end
  endtask : test_codes

  task automatic test_parallel;
    for (int n = 0; n < 8; n++)
    begin
      load_par(8'h01 << n);
      `CHECK(ctrl, 8'h01 << n)
    end
    ser(8'hb3, 8'h3c, 20);
    `CHECK(ctrl, 8'h80)
    sel = 1'b0;
    tick(8);
    ser(8'hb3, 8'h3c, 20);
    `CHECK(ctrl, 8'h3c)
  endtask : test_parallel

  // Lines alternate between two flat levels, so the chroma sign flips from line to line.
  task automatic test_video(input logic [7:0] v);
    logic [7:0] hist [0:127];
    logic [7:0] c;
    logic [7:0] o;
    load_par(v);
    for (int t = 0; t < 100; t++)
    begin
      if (t >= 48)
      begin
        c = hist[t - LAT];
        o = 8'hc8 - c;
        if (v[7])
        begin
          `CHECK(luma, c)
          `CHECK(chroma, ~c)
        end
        else if (v[3:2] == 2'h3)
        begin
          if (hist[t - LAT - 1] == c && hist[t - LAT + 1] == c)
          begin
            `CHECK(luma, c)
            `CHECK(chroma, 8'h80)
          end
        end
        else if (v[0])
        begin
          `CHECK(luma, o)
          `CHECK(chroma, c - o + 8'h80)
        end
        else
        begin
          `CHECK(luma, 8'h64)
          `CHECK(chroma, c + 8'h1c)
        end
      end
      hist[t] = ((t / LINE) % 2 == 1) ? 8'h78 : 8'h50;
      comp = hist[t];
      pins = ~hist[t];
      tick(1);
    end
  endtask : test_video

  initial
  begin
    #200us;
    mismatches++;
    complete_run();
  end

  initial
  begin
    tick(5);
    arst_n = 1'b1;
    test_reset();
    tick(4);
    test_serial();
    test_codes();
    test_parallel();
    test_video(8'h80);
    test_video(8'h78);
    test_video(8'h79);
    test_video(8'h70);
    test_video(8'h75);
    test_video(8'h7c);
    test_reset_held_select();
    complete_run();
  end
endmodule : test_comb_filter_control_and_separation
